//--- pkg/ctu_pkg.sv
// Purpose: Shared constants and types for the charge time unit control
// Assumes: APB slave, 32-bit data, one word per register
// Notes:   Register offsets are local choices

package ctu_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] EDGE_CONTROL_OFS   = 8'h00;
  localparam logic [7:0] CURRENT_CONTROL_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS     = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h0c;
  localparam logic [7:0] UNIT_STATE_OFS     = 8'h10;

  // ***************************************************************
  // Field positions in edge_control
  // ***************************************************************
  localparam int UNIT_ENABLE_BIT   = 15;
  localparam int IDLE_STOP_BIT     = 13;
  localparam int DELAY_GEN_BIT     = 12;
  localparam int EDGE_ACCEPT_BIT   = 11;
  localparam int EDGE_ORDER_BIT    = 10;
  localparam int SOURCE_GROUND_BIT = 9;
  localparam int TRIGGER_OUT_BIT   = 8;
  localparam int EDGE_B_POL_BIT    = 7;
  localparam int EDGE_B_SRC_LSB    = 5;
  localparam int EDGE_A_POL_BIT    = 4;
  localparam int EDGE_A_SRC_LSB    = 2;
  localparam int EDGE_B_SEEN_BIT   = 1;
  localparam int EDGE_A_SEEN_BIT   = 0;

  // Field positions in current_source_control
  localparam int CURRENT_TRIM_LSB  = 10;
  localparam int CURRENT_RANGE_LSB = 8;

  // ***************************************************************
  // Reset values and masks
  // ***************************************************************
  localparam logic [15:0] EDGE_CONTROL_RST    = 16'h0000;
  localparam logic [15:0] CURRENT_CONTROL_RST = 16'h0000;
  localparam logic [15:0] EDGE_CONTROL_MASK   = 16'hbfff;
  localparam logic [15:0] CURRENT_CONTROL_MASK = 16'hff00;
  localparam logic [2:0]  IRQ_RST             = 3'h0;

  // Interrupt status layout
  localparam int IRQ_EDGE_A_BIT = 0;
  localparam int IRQ_EDGE_B_BIT = 1;
  localparam int IRQ_PULSE_BIT  = 2;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    CTU_SRC_TIMER   = 2'h0,
    CTU_SRC_COMPARE = 2'h1,
    CTU_SRC_PIN_B   = 2'h2,
    CTU_SRC_PIN_A   = 2'h3
  } ctu_src_e;

  typedef enum logic [1:0] {
    CTU_RANGE_OFF  = 2'h0,
    CTU_RANGE_BASE = 2'h1,
    CTU_RANGE_X10  = 2'h2,
    CTU_RANGE_X100 = 2'h3
  } ctu_range_e;

  typedef enum logic [3:0] {
    CTU_ST_IDLE   = 4'b0001,
    CTU_ST_WAIT_B = 4'b0010,
    CTU_ST_DELAY  = 4'b0100,
    CTU_ST_DONE   = 4'b1000
  } ctu_state_e;

  typedef struct packed {
    logic edge_pin_a;
    logic edge_pin_b;
    logic compare_unit_one;
    logic timer_unit_one;
  } ctu_edges_s;

  typedef struct packed {
    logic       source_on;
    logic       source_ground;
    logic       route_to_comparator_b;
    ctu_range_e current_range;
    logic [5:0] current_trim;
  } ctu_analog_s;

endpackage : ctu_pkg

//--- core/ctu_core.sv
// Purpose: Control logic of the charge time unit, APB slave
// Assumes: Single clock pclk at 10 MHz, asynchronous active-low reset
// Notes:   Analog source, comparator and converter sit outside
//
// Summary of operation
// - Unit enable gates all unit activity except the ground, range and trim outputs
// - Idle stop halts unit during idle
// - Delay generation enable selects pulse mode
// - Delay mode routes source to comparator B
// - Edge starts charge, trip raises pulse
// - Pulse output is registered on pclk
// - Edge accept enable blocks or passes edges
// - Order enable demands edge A before B
// - Ground bit grounds the current source
// - Polarity one rising, zero falling
// - Edge A source field, four sources
// - Edge seen flags set by hardware
// - Range field scales source current
// - Source on from edge A to edge B, or to trip in delay mode

`timescale 1ns/1ps
`default_nettype none

module ctu_core
  import ctu_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // Edge sources and system state
  input  wire ctu_pkg::ctu_edges_s edges_in,
  input  wire logic                cpu_idle,
  input  wire logic                comparator_trip,
  // Analog controls and outputs
  output var  ctu_pkg::ctu_analog_s analog_ctl,
  output var  logic                pulse_out_pin,
  output var  logic                trigger_out,
  output var  logic                irq
);
  import ctu_pkg::*;

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [15:0] edge_control_reg;
  logic [15:0] current_control_reg;
  logic [2:0]  irq_status_reg;
  logic [2:0]  irq_mask_reg;
  ctu_state_e  state_reg;
  ctu_state_e  state_next;
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic [3:0]  sync3_reg;
  logic [3:0]  level_reg;
  logic        trip_s1_reg;
  logic        trip_s2_reg;
  logic        trip_s3_reg;
  logic        trip_reg;

  // ***************************************************************
  // Input synchronisers, change taken when stages two and three agree
  // ***************************************************************
  logic [3:0] raw_edges;
  logic [3:0] level_next;
  assign raw_edges = {edges_in.edge_pin_a, edges_in.edge_pin_b,
                      edges_in.compare_unit_one, edges_in.timer_unit_one};

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      level_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : level_reg[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg   <= 4'h0;
      sync2_reg   <= 4'h0;
      sync3_reg   <= 4'h0;
      level_reg   <= 4'h0;
      trip_s1_reg <= 1'b0;
      trip_s2_reg <= 1'b0;
      trip_s3_reg <= 1'b0;
      trip_reg    <= 1'b0;
    end else begin
      sync1_reg   <= raw_edges;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      level_reg   <= level_next;
      trip_s1_reg <= comparator_trip;
      trip_s2_reg <= trip_s1_reg;
      trip_s3_reg <= trip_s2_reg;
      if (trip_s2_reg == trip_s3_reg) begin
        trip_reg <= trip_s3_reg;
      end
    end
  end

  // ***************************************************************
  // Edge selection and detection
  // ***************************************************************
  function automatic logic pick_source(input logic [1:0] sel, input logic [3:0] lv);
    unique case (ctu_src_e'(sel))
      CTU_SRC_PIN_A:   pick_source = lv[3];
      CTU_SRC_PIN_B:   pick_source = lv[2];
      CTU_SRC_COMPARE: pick_source = lv[1];
      CTU_SRC_TIMER:   pick_source = lv[0];
    endcase
  endfunction

  function automatic logic edge_hit(input logic pol, input logic prev, input logic cur);
    edge_hit = pol ? (!prev && cur) : (prev && !cur);
  endfunction

  logic active;
  logic edge_a_event;
  logic edge_b_event;
  logic edge_a_seen;
  logic edge_b_seen;

  assign active = edge_control_reg[UNIT_ENABLE_BIT] &&
                  !(edge_control_reg[IDLE_STOP_BIT] && cpu_idle);
  assign edge_a_seen = edge_control_reg[EDGE_A_SEEN_BIT];
  assign edge_b_seen = edge_control_reg[EDGE_B_SEEN_BIT];

  assign edge_a_event = active && edge_control_reg[EDGE_ACCEPT_BIT] &&
    edge_hit(edge_control_reg[EDGE_A_POL_BIT],
             pick_source(edge_control_reg[EDGE_A_SRC_LSB +: 2], level_reg),
             pick_source(edge_control_reg[EDGE_A_SRC_LSB +: 2], level_next));
  assign edge_b_event = active && edge_control_reg[EDGE_ACCEPT_BIT] &&
    (!edge_control_reg[EDGE_ORDER_BIT] || edge_a_seen) &&
    edge_hit(edge_control_reg[EDGE_B_POL_BIT],
             pick_source(edge_control_reg[EDGE_B_SRC_LSB +: 2], level_reg),
             pick_source(edge_control_reg[EDGE_B_SRC_LSB +: 2], level_next));

  // ***************************************************************
  // APB access
  // ***************************************************************
  logic wr_en;
  logic addr_ok;
  assign wr_en   = psel && penable && pwrite;
  assign addr_ok = (paddr == EDGE_CONTROL_OFS) || (paddr == CURRENT_CONTROL_OFS) ||
                   (paddr == IRQ_STATUS_OFS) || (paddr == IRQ_MASK_OFS) ||
                   (paddr == UNIT_STATE_OFS);

  // Edge control with hardware-set seen flags; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_control_reg <= EDGE_CONTROL_RST;
    end else begin
      if (wr_en && paddr == EDGE_CONTROL_OFS) begin
        edge_control_reg <= pwdata[15:0] & EDGE_CONTROL_MASK;
      end
      if (edge_a_event) begin
        edge_control_reg[EDGE_A_SEEN_BIT] <= 1'b1;
      end
      if (edge_b_event) begin
        edge_control_reg[EDGE_B_SEEN_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_control_reg <= CURRENT_CONTROL_RST;
    end else if (wr_en && paddr == CURRENT_CONTROL_OFS) begin
      current_control_reg <= pwdata[15:0] & CURRENT_CONTROL_MASK;
    end
  end

  // Interrupt status, write one to clear, set wins
  logic [2:0] irq_events;
  logic       pulse_rise;
  assign irq_events = {pulse_rise, edge_b_event, edge_a_event};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= IRQ_RST;
      irq_mask_reg   <= IRQ_RST;
    end else begin
      irq_status_reg <= (irq_status_reg &
        ~((wr_en && paddr == IRQ_STATUS_OFS) ? pwdata[2:0] : 3'h0)) | irq_events;
      if (wr_en && paddr == IRQ_MASK_OFS) begin
        irq_mask_reg <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Read data and response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          EDGE_CONTROL_OFS:    prdata <= {16'h0000, edge_control_reg};
          CURRENT_CONTROL_OFS: prdata <= {16'h0000, current_control_reg};
          IRQ_STATUS_OFS:      prdata <= {29'h0, irq_status_reg};
          IRQ_MASK_OFS:        prdata <= {29'h0, irq_mask_reg};
          UNIT_STATE_OFS:      prdata <= {27'h0, trip_reg, state_reg};
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  logic delay_mode;
  assign delay_mode = edge_control_reg[DELAY_GEN_BIT];

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CTU_ST_IDLE: begin
        if (edge_a_event && !edge_b_seen) begin
          state_next = delay_mode ? CTU_ST_DELAY : CTU_ST_WAIT_B;
        end
      end
      CTU_ST_WAIT_B: begin
        if (edge_b_event || edge_b_seen) begin
          state_next = CTU_ST_DONE;
        end
      end
      CTU_ST_DELAY: begin
        if (trip_reg) begin
          state_next = CTU_ST_DONE;
        end
      end
      CTU_ST_DONE: begin
        if (!edge_a_seen && !edge_b_seen) begin
          state_next = CTU_ST_IDLE;
        end
      end
      default: state_next = CTU_ST_IDLE;
    endcase
    if (!active) begin
      state_next = CTU_ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= CTU_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign pulse_rise = (state_reg == CTU_ST_DELAY) && (state_next == CTU_ST_DONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctl    <= '{source_on: 1'b0, source_ground: 1'b0,
                         route_to_comparator_b: 1'b0, current_range: CTU_RANGE_OFF,
                         current_trim: 6'h00};
      pulse_out_pin <= 1'b0;
      trigger_out   <= 1'b0;
    end else begin
      analog_ctl.source_on <= (state_next == CTU_ST_WAIT_B) ||
                              (state_next == CTU_ST_DELAY);
      analog_ctl.source_ground <= edge_control_reg[SOURCE_GROUND_BIT];
      analog_ctl.route_to_comparator_b <= active && delay_mode;
      analog_ctl.current_range <=
        ctu_range_e'(current_control_reg[CURRENT_RANGE_LSB +: 2]);
      analog_ctl.current_trim <= current_control_reg[CURRENT_TRIM_LSB +: 6];
      // Registered from the DONE state in delay mode; the true asynchronous pulse is formed
      // in the analog macro from the trip itself
      pulse_out_pin <= delay_mode && (state_next == CTU_ST_DONE);
      trigger_out <= edge_control_reg[TRIGGER_OUT_BIT] &&
                     (state_reg == CTU_ST_WAIT_B) && (state_next == CTU_ST_DONE);
    end
  end

endmodule // ctu_core

`default_nettype wire

//--- test/ctu_core_checker.sv
// Purpose: Port assertions for ctu_core
// Assumes: A write lands at the APB access edge
// Notes:   Shadows both control registers
`timescale 1ns/1ps
`default_nettype none
module ctu_core_checker
  import ctu_pkg::*;
(
  // Clock, reset and APB
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Unit outputs
  input wire ctu_pkg::ctu_analog_s analog_ctl,
  input wire logic                 pulse_out_pin,
  input wire logic                 trigger_out
);
  // ************************************************************
  // Register shadows
  // ************************************************************
  logic [15:0] ctl_q;
  logic [15:0] cur_q;
  wire         wr_ok = psel && penable && pwrite && pready && !pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= '0;
      cur_q <= '0;
    end else if (wr_ok && paddr == EDGE_CONTROL_OFS) begin
      ctl_q <= pwdata[15:0];
    end else if (wr_ok && paddr == CURRENT_CONTROL_OFS) begin
      cur_q <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (psel && !penable |=> penable && pready)
    else $error("no answer in access cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  AST_UNIT_OFF: assert property (!ctl_q[15] [*3] |-> !analog_ctl.source_on)
    else $error("source on while unit disabled");
  AST_GROUND: assert property ($stable(ctl_q[9]) |-> analog_ctl.source_ground == ctl_q[9])
    else $error("ground control mismatch");
  AST_RANGE: assert property ($stable(cur_q[9:8]) |-> analog_ctl.current_range == cur_q[9:8])
    else $error("range mismatch");
  AST_TRIM: assert property ($stable(cur_q[15:10]) |-> analog_ctl.current_trim == cur_q[15:10])
    else $error("trim mismatch");
  AST_ROUTE: assert property (analog_ctl.route_to_comparator_b |-> ctl_q[12] || $past(ctl_q[12]))
    else $error("routed outside delay mode");
  AST_PULSE: assert property (pulse_out_pin |-> ctl_q[12] || $past(ctl_q[12]))
    else $error("pulse outside delay mode");
  AST_TRIG: assert property (trigger_out |-> (ctl_q[8] || $past(ctl_q[8])) ##1 !trigger_out)
    else $error("trigger not a single enabled pulse");
endmodule // ctu_core_checker
bind ctu_core ctu_core_checker u_ctu_core_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .analog_ctl(analog_ctl), .pulse_out_pin(pulse_out_pin), .trigger_out(trigger_out)
);
`default_nettype wire

//--- test/ctu_edge_model.sv
// Purpose: Edge sources and delay capacitor beside the unit
// Assumes: Bench commands edge levels
// Notes:   Trip after a fixed charge time
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_model
  import ctu_pkg::*;
#(
  parameter int CHARGE_CYCLES = 20
)
(
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Commands and analog state
  input  wire ctu_pkg::ctu_edges_s  level_cmd,
  input  wire ctu_pkg::ctu_analog_s analog_ctl,
  // Lines into the unit
  output var  ctu_pkg::ctu_edges_s  edges_out,
  output var  logic                 comparator_trip
);
  logic [7:0] charge_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) edges_out <= '0;
    else edges_out <= level_cmd;
  end
  // Capacitor charges only from a live, routed, ungrounded source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) charge_reg <= '0;
    else if (!analog_ctl.source_on || !analog_ctl.route_to_comparator_b) charge_reg <= '0;
    else if (!analog_ctl.source_ground && charge_reg < 8'(CHARGE_CYCLES)) charge_reg <= charge_reg + 8'h01;
  end
  assign comparator_trip = (charge_reg == 8'(CHARGE_CYCLES));
endmodule // ctu_edge_model
`default_nettype wire

//--- test/edge_timed_current_source_control_tb_top.sv
// Purpose: Self-checking bench for ctu_core
// Assumes: APB answer awaited until the bench timeout
// Notes:   Edges taken within 8 cycles
`timescale 1ns/1ps
`default_nettype none
module edge_timed_current_source_control_tb_top;
  import ctu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, cpu_idle, trip, pls, trg, irq, se, rdy, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ctlw;
  ctu_edges_s  lvl_cmd, edges;
  ctu_analog_s actl;
  int          err_count, n_compared, trig_cnt, cycles, n;
  ctu_core u_ctu_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(rdy),
    .pslverr(err), .edges_in(edges), .cpu_idle(cpu_idle), .comparator_trip(trip),
    .analog_ctl(actl), .pulse_out_pin(pls), .trigger_out(trg), .irq(irq));
  ctu_edge_model #(.CHARGE_CYCLES(20)) u_ctu_edge_model (.pclk(pclk), .presetn(presetn),
    .level_cmd(lvl_cmd), .analog_ctl(actl), .edges_out(edges), .comparator_trip(trip));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (trg === 1'b1) trig_cnt++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (rdy !== 1'b1);
    rd = prdata;
    se = err;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fire(input int code, input logic lvl);
    lvl_cmd[code] <= lvl;
    repeat (8) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, cpu_idle, presetn, paddr, pwdata, lvl_cmd} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, EDGE_CONTROL_OFS, 0);
    chk("edge_control reset", rd, 32'h0);
    apb(0, 8'h14, 0);
    chk("unmapped error", se, 1);
    for (int r = 0; r < 4; r++) begin
      apb(1, CURRENT_CONTROL_OFS, 32'hffff00ff | ((r * 21) << 10) | (r << 8));
      apb(0, CURRENT_CONTROL_OFS, 0);
      chk("current_source_control", rd, ((r * 21) << 10) | (r << 8));
      chk("current_range", actl.current_range, r);
      chk("current_trim", actl.current_trim, r * 21);
    end
    $display("test current settings done");
    for (int s = 0; s < 4; s++) begin
      lvl_cmd <= {4{~s[0]}};
      ctlw = 16'h8d00 | (s[0] << 7) | (((s + 1) % 4) << 5) | (s[0] << 4) | (s << 2);
      apb(1, EDGE_CONTROL_OFS, ctlw | (s == 3 ? 16'h0200 : 16'h0));
      trig_cnt = 0;
      fire((s + 1) % 4, s[0]);
      apb(0, EDGE_CONTROL_OFS, 0);
      chk("seen after early b", rd[1:0], 0);
      fire((s + 1) % 4, ~s[0]);
      fire(s, s[0]);
      chk("source_on after a", actl.source_on, 1);
      apb(0, EDGE_CONTROL_OFS, 0);
      chk("seen after a", rd[1:0], 1);
      fire((s + 1) % 4, s[0]);
      chk("source_on after b", actl.source_on, 0);
      apb(0, EDGE_CONTROL_OFS, 0);
      chk("seen after b", rd[1:0], 3);
      chk("trigger pulses", trig_cnt, 1);
      apb(1, EDGE_CONTROL_OFS, 0);
    end
    $display("test measurement done");
    lvl_cmd <= '0;
    apb(1, EDGE_CONTROL_OFS, 16'h801c);
    fire(3, 1);
    apb(0, EDGE_CONTROL_OFS, 0);
    chk("seen with edges blocked", rd[1:0], 0);
    fire(3, 0);
    cpu_idle <= 1'b1;
    apb(1, EDGE_CONTROL_OFS, 16'ha81c);
    fire(3, 1);
    apb(0, EDGE_CONTROL_OFS, 0);
    chk("seen when stopped in idle", rd[1:0], 0);
    fire(3, 0);
    apb(1, EDGE_CONTROL_OFS, 16'h881c);
    fire(3, 1);
    apb(0, EDGE_CONTROL_OFS, 0);
    chk("seen when running in idle", rd[1:0], 1);
    cpu_idle <= 1'b0;
    lvl_cmd <= '0;
    apb(1, EDGE_CONTROL_OFS, 0);
    apb(1, IRQ_MASK_OFS, 4);
    apb(1, EDGE_CONTROL_OFS, 16'h981c);
    fire(3, 1);
    chk("route to comparator", actl.route_to_comparator_b, 1);
    while (pls !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("pulse_out_pin", pls, 1);
    repeat (2) @(posedge pclk);
    chk("irq on pulse", irq, 1);
    apb(1, IRQ_STATUS_OFS, 7);
    repeat (2) @(posedge pclk);
    chk("irq after clear", irq, 0);
    apb(0, UNIT_STATE_OFS, 0);
    chk("unit state done", rd, 32'h8);
    apb(1, EDGE_CONTROL_OFS, 0);
    $display("test delay generation done");
    give_verdict();
  end
endmodule // edge_timed_current_source_control_tb_top
`default_nettype wire
